// ===== logic/rgd_peak_hold.sv
// peak-hold of one 4-bit rssi code
`timescale 1ns/1ps
`default_nettype none
module rgd_peak_hold (
   input wire logic clock,
   input wire logic rst_n,
   rgd_peak_if.tracker pk
);
   logic [3:0] peak;
   wire higher = pk.sampleValid && (pk.sample > peak);
   assign pk.peak = peak;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         peak <= rgd_pkg::CODE_ZERO;
      end else if (pk.clear) begin
         peak <= rgd_pkg::CODE_ZERO; // R8
      end else if (higher) begin
         peak <= pk.sample; // R13
      end
   end
   AST_PEAK_NO_DROP: assert property (@(posedge clock) disable iff (!rst_n)
      !$past(pk.clear) |-> peak >= $past(peak)) else $error("peak fell without clear"); // R13
endmodule
`default_nettype wire

// ===== logic/rgd_peak_if.sv
// interface: peak tracker signals between main block and tracker
`timescale 1ns/1ps
`default_nettype none
interface rgd_peak_if;
   logic sampleValid;
   logic [3:0] sample;
   logic clear;
   logic [3:0] peak;
   modport owner (output sampleValid, output sample, output clear, input peak);
   modport tracker (input sampleValid, input sample, input clear, output peak);
endinterface
`default_nettype wire

// ===== logic/rgd_pkg.sv
// package: register offsets, fields and encodings of the regulator/rssi/gain group
package rgd_pkg;
   // register indices (printed offsets are not all multiples of four)
   localparam logic [7:0] IDX_REG_CTRL = 8'h2C;
   localparam logic [7:0] IDX_REG_DISP = 8'h2C;
   localparam logic [7:0] IDX_STRENGTH = 8'h2D;
   localparam logic [7:0] IDX_GAIN_CUT = 8'h2E;
   localparam logic [7:0] IDX_SPACE_SEL = 8'h3F;
   localparam int ADDR_W = 10;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int CTRL_MODE_BIT = 7;
   localparam int CODE_HI = 6;
   localparam int CODE_LO = 3;
   localparam int SRC_HI = 2;
   localparam int LIM_BIT = 0;
   localparam logic [3:0] CODE_FIXED_HIGH = 4'hF;
   localparam logic [3:0] CODE_ZERO = 4'h0;
   localparam logic [2:0] SRC_RESERVED_LO = 3'h6;
   typedef enum logic [2:0] {
      RGD_SRC_MAIN, RGD_SRC_ANALOG, RGD_SRC_DIGITAL, RGD_SRC_RF, RGD_SRC_AM, RGD_SRC_TX
   } rgd_source_t;
   // byte address of a register index
   function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
      byte_addr = {idx, 2'b00};
   endfunction
endpackage

// ===== logic/rgd_regs.sv
// regulator control, regulator display, rssi peak and gain reduction registers
// Operation
// (R1) spaces A and B share 2Ch: A is the control, B the regulator display.
// (R2) control bit 7 picks adjust-command result or manual code for regulators.
// (R3) control bits 6:3 hold the manual 4-bit regulated-voltage code.
// (R4) low-supply: digital/analog follow rf setting; high-supply: fixed top code.
// (R5) control bits 2:0 select supply measure source; 110 and 111 reserved.
// (R6) display bits 7:4 show code from last adjust command.
// (R7) display bit 0 shows rf regulator current limit; bits 3:1 read zero.
// (R8) rssi bits 7:4 hold am peak until next reception or clear.
// (R9) rssi bits 3:0 hold pm peak until next reception or clear.
// (R10) rssi codes rise monotonically with level; passed through unchanged.
// (R11) gain register bits 7:4 show total am gain reduction.
// (R12) gain register bits 3:0 show total pm gain reduction.
// (R13) a peak field updates only when a new sample exceeds it.
// (R14) writes to display registers are ignored.
`timescale 1ns/1ps
`default_nettype none
module rgd_regs (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [rgd_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic [1:0] response,
   input wire logic [3:0] adjustCode,
   input wire logic currentLimit,
   input wire logic highSupply,
   input wire logic receptionStart,
   input wire logic strengthClear,
   input wire logic strengthValid,
   input wire logic [3:0] amStrengthSample,
   input wire logic [3:0] pmStrengthSample,
   input wire logic [3:0] amGainCut,
   input wire logic [3:0] pmGainCut,
   output logic [3:0] rfSupplyCode,
   output logic [3:0] coreSupplyCode,
   output logic [2:0] measureSourceSelect,
   output logic spaceB
);
   logic rstMeta, rst_n;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rstMeta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rst_n <= rstMeta;
      end
   end

   rgd_peak_if amPk ();
   rgd_peak_if pmPk ();
   rgd_peak_hold amHold (.clock(clock), .rst_n(rst_n), .pk(amPk));
   rgd_peak_hold pmHold (.clock(clock), .rst_n(rst_n), .pk(pmPk));
   wire peakClear = receptionStart || strengthClear;
   assign amPk.clear = peakClear; // R8
   assign pmPk.clear = peakClear; // R9
   assign amPk.sampleValid = strengthValid;
   assign pmPk.sampleValid = strengthValid;
   assign amPk.sample = amStrengthSample; // R10
   assign pmPk.sample = pmStrengthSample; // R10

   logic [7:0] control;
   logic [7:0] regDisplay, strength, gainCut;
   logic [31:0] rdata;
   logic ack;

   // one-cycle wait, answer on second edge
   wire req = read || write;
   wire lowWrite = write && byteenable[0];
   wire hitCtrl = address == rgd_pkg::byte_addr(rgd_pkg::IDX_REG_CTRL);
   wire hitStrength = address == rgd_pkg::byte_addr(rgd_pkg::IDX_STRENGTH);
   wire hitGain = address == rgd_pkg::byte_addr(rgd_pkg::IDX_GAIN_CUT);
   wire hitSpace = address == rgd_pkg::byte_addr(rgd_pkg::IDX_SPACE_SEL);
   wire hitAny = hitCtrl || hitStrength || hitGain || hitSpace;
   wire ctrlWrite = ack && lowWrite && hitCtrl && !spaceB; // R1 R14
   wire spaceWrite = ack && lowWrite && hitSpace;

   assign waitrequest = req && !ack;
   assign readdata = rdata;

   wire manual = control[rgd_pkg::CTRL_MODE_BIT];
   wire [3:0] manualCode = control[rgd_pkg::CODE_HI:rgd_pkg::CODE_LO]; // R3
   wire [3:0] next_rf = manual ? manualCode : adjustCode; // R2
   wire [3:0] next_core = highSupply ? rgd_pkg::CODE_FIXED_HIGH : next_rf; // R4
   wire [2:0] srcField = control[rgd_pkg::SRC_HI:0]; // R5

   always_comb begin
      regDisplay = {adjustCode, 3'b000, currentLimit}; // R6 R7
      strength = {amPk.peak, pmPk.peak}; // R8 R9
      gainCut = {amGainCut, pmGainCut}; // R11 R12
   end

   wire [7:0] ctrlView = spaceB ? regDisplay : control; // R1
   wire [7:0] next_byte = hitCtrl ? ctrlView :
                          hitStrength ? (spaceB ? 8'h00 : strength) :
                          hitGain ? (spaceB ? 8'h00 : gainCut) :
                          {7'h00, spaceB};

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= req && !ack;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         control <= rgd_pkg::CTRL_RESET;
         spaceB <= 1'b0;
      end else begin
         if (ctrlWrite) begin
            control <= writedata[7:0]; // R2 R3 R5
         end
         if (spaceWrite) begin
            spaceB <= writedata[0];
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h00000000;
         response <= 2'b00;
         rfSupplyCode <= rgd_pkg::CODE_ZERO;
         coreSupplyCode <= rgd_pkg::CODE_ZERO;
         measureSourceSelect <= 3'h0;
      end else begin
         rfSupplyCode <= next_rf;
         coreSupplyCode <= next_core;
         measureSourceSelect <= srcField;
         if (req && !ack) begin
            rdata <= (read && hitAny) ? {24'h000000, next_byte} : 32'h00000000;
            response <= hitAny ? 2'b00 : 2'b11;
         end
      end
   end

   AST_MODE_MANUAL: assert property (@(posedge clock) disable iff (!rst_n)
      manual |=> rfSupplyCode == $past(manualCode)) else $error("manual code not applied"); // R2
   AST_MODE_AUTO: assert property (@(posedge clock) disable iff (!rst_n)
      !manual |=> rfSupplyCode == $past(adjustCode)) else $error("adjust code not applied"); // R2
   AST_CORE_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
      highSupply |=> coreSupplyCode == rgd_pkg::CODE_FIXED_HIGH) else $error("core not fixed"); // R4
   AST_CORE_LOW: assert property (@(posedge clock) disable iff (!rst_n)
      !highSupply |=> coreSupplyCode == rfSupplyCode) else $error("core not following rf"); // R4
   AST_SRC: assert property (@(posedge clock) disable iff (!rst_n)
      1'b1 |=> measureSourceSelect == $past(srcField)) else $error("source mismatch"); // R5
   AST_CTRL_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
      ctrlWrite |=> control == $past(writedata[7:0])) else $error("control write lost"); // R3
   AST_RO_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
      (write && spaceB && hitCtrl) |=> control == $past(control)) else $error("display write landed"); // R14
   AST_DISP_READ: assert property (@(posedge clock) disable iff (!rst_n)
      (read && ack && hitCtrl && spaceB) |-> readdata[3:1] == 3'b000) else $error("reserved bits set"); // R7
   AST_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
      peakClear |=> strength == 8'h00) else $error("peak not cleared"); // R8
   AST_ANSWER: assert property (@(posedge clock) disable iff (!rst_n)
      (req && !ack) |=> !waitrequest) else $error("no answer in two edges"); // R1
   COV_MANUAL: cover property (@(posedge clock) ctrlWrite && writedata[7]);
   COV_SPACEB_READ: cover property (@(posedge clock) read && ack && hitCtrl && spaceB);
   COV_PEAK: cover property (@(posedge clock) strengthValid && amStrengthSample > amPk.peak);
endmodule
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench of the regulator, rssi and gain register group
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clock = 1'h0;
   logic nrst = 1'h0;
   logic [rgd_pkg::ADDR_W-1:0] address = '0;
   logic read = 1'h0;
   logic write = 1'h0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'h1;
   logic [3:0] adjustCode = 4'h6;
   logic currentLimit = 1'h1;
   logic highSupply = 1'h0;
   logic receptionStart = 1'h0;
   logic strengthClear = 1'h0;
   logic strengthValid = 1'h0;
   logic [3:0] amStrengthSample = 4'h0;
   logic [3:0] pmStrengthSample = 4'h0;
   logic [3:0] amGainCut = 4'h0;
   logic [3:0] pmGainCut = 4'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic [1:0] response;
   logic [3:0] rfSupplyCode;
   logic [3:0] coreSupplyCode;
   logic [2:0] measureSourceSelect;
   logic spaceB;
   int error_cnt = 0;
   int checked = 0;
   rgd_regs dut_u (.clock, .nrst, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
      .response, .adjustCode, .currentLimit, .highSupply, .receptionStart, .strengthClear, .strengthValid,
      .amStrengthSample, .pmStrengthSample, .amGainCut, .pmGainCut, .rfSupplyCode, .coreSupplyCode,
      .measureSourceSelect, .spaceB);
   initial begin
      forever #2.5 clock = ~clock;
   end
   task automatic stop_test;
      if (error_cnt == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one bus access; reads compare data, all compare response
   task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [7:0] exp,
         input logic [1:0] rsp);
      int n;
      n = 0;
      address <= {idx, 2'h0};
      writedata <= {24'h0, wd};
      read <= ~wr;
      write <= wr;
      do begin
         @(negedge clock);
         n++;
      end while (waitrequest !== 1'h0 && n < 20);
      if (waitrequest !== 1'h0) begin
         error_cnt++;
         stop_test();
      end
      @(posedge clock);
      if (!wr) chk(readdata, {24'h0, exp});
      chk(response, rsp);
      read <= 1'h0;
      write <= 1'h0;
      @(posedge clock);
   endtask
   // kind 0 sample, 1 clear command, 2 reception start
   task automatic feed(input logic [3:0] am, input logic [3:0] pm, input int kind);
      amStrengthSample <= am;
      pmStrengthSample <= pm;
      strengthValid <= (kind == 0);
      strengthClear <= (kind == 1);
      receptionStart <= (kind == 2);
      @(posedge clock);
      strengthValid <= 1'h0;
      strengthClear <= 1'h0;
      receptionStart <= 1'h0;
      @(posedge clock);
   endtask
   task automatic scn_reset;
      acc(1'h0, 8'h2C, 8'h00, 8'h00, 2'h0);
      chk(spaceB, 1'h0);
      chk(rfSupplyCode, 4'h6);
      chk(measureSourceSelect, 3'h0);
   endtask
   task automatic scn_control;
      for (int s = 0; s < 6; s++) begin
         acc(1'h1, 8'h2C, {1'h1, 4'hA, s[2:0]}, 8'h00, 2'h0);
         acc(1'h0, 8'h2C, 8'h00, {1'h1, 4'hA, s[2:0]}, 2'h0);
         chk(measureSourceSelect, s[2:0]);
      end
      chk(rfSupplyCode, 4'hA);
      chk(coreSupplyCode, 4'hA);
      highSupply <= 1'h1;
      repeat (2) @(posedge clock);
      chk(coreSupplyCode, 4'hF);
      highSupply <= 1'h0;
      acc(1'h1, 8'h2C, 8'h55, 8'h00, 2'h0);
      @(negedge clock);
      chk(rfSupplyCode, 4'h6);
      chk(coreSupplyCode, 4'h6);
   endtask
   task automatic scn_spaces;
      adjustCode <= 4'h9;
      acc(1'h1, 8'h3F, 8'h01, 8'h00, 2'h0);
      chk(spaceB, 1'h1);
      acc(1'h0, 8'h2C, 8'h00, 8'h91, 2'h0);
      acc(1'h1, 8'h2C, 8'hFF, 8'h00, 2'h0);
      currentLimit <= 1'h0;
      acc(1'h0, 8'h2C, 8'h00, 8'h90, 2'h0);
      acc(1'h1, 8'h3F, 8'h00, 8'h00, 2'h0);
      acc(1'h0, 8'h2C, 8'h00, 8'h55, 2'h0);
   endtask
   task automatic scn_peaks;
      feed(4'h0, 4'h0, 2);
      feed(4'h3, 4'h9, 0);
      feed(4'h5, 4'h2, 0);
      feed(4'h4, 4'hB, 0);
      acc(1'h0, 8'h2D, 8'h00, 8'h5B, 2'h0);
      acc(1'h1, 8'h2D, 8'h00, 8'h00, 2'h0);
      acc(1'h0, 8'h2D, 8'h00, 8'h5B, 2'h0);
      feed(4'h0, 4'h0, 1);
      acc(1'h0, 8'h2D, 8'h00, 8'h00, 2'h0);
      feed(4'hF, 4'hE, 0);
      acc(1'h0, 8'h2D, 8'h00, 8'hFE, 2'h0);
      feed(4'h0, 4'h0, 2);
      acc(1'h0, 8'h2D, 8'h00, 8'h00, 2'h0);
   endtask
   task automatic scn_gain;
      amGainCut <= 4'hC;
      pmGainCut <= 4'h3;
      acc(1'h0, 8'h2E, 8'h00, 8'hC3, 2'h0);
      acc(1'h1, 8'h2E, 8'h00, 8'h00, 2'h0);
      pmGainCut <= 4'hA;
      acc(1'h0, 8'h2E, 8'h00, 8'hCA, 2'h0);
      acc(1'h0, 8'h10, 8'h00, 8'h00, 2'h3);
   endtask
   initial begin
      repeat (4) @(posedge clock);
      nrst <= 1'h1;
      repeat (3) @(posedge clock);
      scn_reset();
      scn_control();
      scn_spaces();
      scn_peaks();
      scn_gain();
      stop_test();
   end
endmodule
`default_nettype wire
